// ==== hbpwm_top.sv ====
// Module: eight half-bridge PWM driver control with fault latching
`timescale 1ns/1ps
module hbpwm_top
  import hbpwm_pkg::*;
#(
  parameter int NB = NUM_BRIDGES,
  parameter int NC = NUM_CHANNELS
) (
  // Clock, reset and sleep
  input  wire logic            core_clk_i,
  input  wire logic            resetn_i,
  input  wire logic            enable_i,
  // Bridge control
  input  wire logic [NB-1:0]   bridge_high_side_enable_i,
  input  wire logic [NB-1:0]   bridge_low_side_enable_i,
  input  wire logic [2*NB-1:0] bridge_channel_assign_control_i,
  input  wire logic [NB-1:0]   free_wheeling_i,
  // Channel settings
  input  wire logic [8*NC-1:0] duty_cycle_control_i,
  input  wire logic [2*NC-1:0] channel_rate_field_i,
  input  wire logic [NC-1:0]   channel_fast_rate_bit_i,
  // Analog monitor inputs (asynchronous)
  input  wire logic [NB-1:0]   hs_overcurrent_i,
  input  wire logic [NB-1:0]   ls_overcurrent_i,
  input  wire logic [NB-1:0]   hs_open_load_i,
  input  wire logic [NB-1:0]   ls_open_load_i,
  input  wire logic            temp_warn_i,
  input  wire logic            temp_shutdown_i,
  input  wire logic            supply_under_i,
  input  wire logic            supply_over_i,
  // Flag clear strobes, one cycle each
  input  wire logic [NB-1:0]   clear_hs_oc_i,
  input  wire logic [NB-1:0]   clear_ls_oc_i,
  input  wire logic [NB-1:0]   clear_hs_ol_i,
  input  wire logic [NB-1:0]   clear_ls_ol_i,
  input  wire logic [7:0]      clear_global_i,
  // Gate drives
  output logic [NB-1:0]        high_gate_o,
  output logic [NB-1:0]        low_gate_o,
  // Status
  output logic [NB-1:0]        high_side_overcurrent_flag_o,
  output logic [NB-1:0]        low_side_overcurrent_flag_o,
  output logic [NB-1:0]        high_side_open_load_flag_o,
  output logic [NB-1:0]        low_side_open_load_flag_o,
  output logic [7:0]           global_status_o,
  output logic                 fault_indicator_n_o
);
  localparam int NMON = 4 * NB + 4;
  // ************************************************************
  // Reset, sleep and input synchronisers
  // ************************************************************
  logic            en_s1, en_s2;
  logic            rst_all;
  logic [NMON-1:0] mon_s1, mon_s2, mon_raw;
  logic [NB-1:0]   oc_h, oc_l, ol_h, ol_l;
  logic            t_warn, t_sd, s_uv, s_ov;

  assign mon_raw = {hs_overcurrent_i, ls_overcurrent_i, hs_open_load_i,
                    ls_open_load_i, temp_warn_i, temp_shutdown_i,
                    supply_under_i, supply_over_i};
  assign {oc_h, oc_l, ol_h, ol_l, t_warn, t_sd, s_uv, s_ov} = mon_s2;

  // Enable and monitor pins pass two flops before use
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      en_s1  <= 1'b0;
      en_s2  <= 1'b0;
      mon_s1 <= '0;
      mon_s2 <= '0;
    end else begin
      en_s1  <= enable_i;
      en_s2  <= en_s1;
      mon_s1 <= mon_raw;
      mon_s2 <= mon_s1;
    end
  end

  // Sleep holds the whole block in reset
  assign rst_all = !resetn_i || !en_s2;

  // ************************************************************
  // PWM channels
  // ************************************************************
  hbpwm_chan_if ch_if ();
  genvar c;
  generate
    for (c = 0; c < NC; c++) begin : g_ch
      hbpwm_channel #(.DW(DUTY_BITS)) u_ch (
        .core_clk_i (core_clk_i),
        .resetn_i   (!rst_all),
        .duty_i     (duty_cycle_control_i[8*c +: 8]),
        .rate_i     (channel_rate_field_i[2*c +: 2]),
        .fast_i     (channel_fast_rate_bit_i[c]),
        .pwm_on_o   (ch_if.pwm_on[c]),
        .running_o  (ch_if.running[c])
      );
    end
  endgenerate

  // ************************************************************
  // Fault flags
  // ************************************************************
  // Set wins over clear so a live condition re-latches at once
  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      high_side_overcurrent_flag_o <= '0;
      low_side_overcurrent_flag_o  <= '0;
      high_side_open_load_flag_o   <= '0;
      low_side_open_load_flag_o    <= '0;
    end else begin
      high_side_overcurrent_flag_o <= oc_h |
        (high_side_overcurrent_flag_o & ~clear_hs_oc_i);
      low_side_overcurrent_flag_o <= oc_l |
        (low_side_overcurrent_flag_o & ~clear_ls_oc_i);
      high_side_open_load_flag_o <= ol_h |
        (high_side_open_load_flag_o & ~clear_hs_ol_i);
      low_side_open_load_flag_o <= ol_l |
        (low_side_open_load_flag_o & ~clear_ls_ol_i);
    end
  end

  logic [7:0] next_gs;
  logic       load_err;
  assign load_err = |{oc_h, oc_l, ol_h, ol_l};

  // Global status: sticky bits, host clear strobes per bit; the strobe on bit 0 sets it
  always_comb begin
    next_gs = global_status_o & ~clear_global_i;
    next_gs[GS_POR_SEEN] = global_status_o[GS_POR_SEEN]
                           | clear_global_i[GS_POR_SEEN];
    next_gs[GS_TPW] = next_gs[GS_TPW] | t_warn;
    next_gs[GS_TSD] = next_gs[GS_TSD] | t_sd;
    next_gs[GS_OV]  = next_gs[GS_OV]  | s_ov;
    next_gs[GS_UV]  = next_gs[GS_UV]  | s_uv;
    next_gs[GS_LE]  = next_gs[GS_LE]  | load_err;
    next_gs[3] = 1'b0;
    next_gs[7] = 1'b0;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_all) global_status_o <= GS_RST;
    else         global_status_o <= next_gs;
  end

  // Fault pin low whenever a global status bit from GS_TPW to GS_LE is set
  always_ff @(posedge core_clk_i) begin
    if (rst_all) fault_indicator_n_o <= 1'b1;
    else fault_indicator_n_o <= !(|next_gs[GS_LE:GS_TPW]);
  end

  // ************************************************************
  // Bridge legs
  // ************************************************************
  logic all_off;
  // Thermal latch persists; supply faults follow the live level
  assign all_off = global_status_o[GS_TSD] || s_uv || s_ov;

  genvar b;
  generate
    for (b = 0; b < NB; b++) begin : g_leg
      logic [1:0]  asg;
      logic        assigned, pwm, run, want_h, want_l;
      logic [3:0]  dead_cnt;
      hbpwm_leg_t  st;
      assign asg      = bridge_channel_assign_control_i[2*b +: 2];
      assign assigned = (asg != ASSIGN_NONE);
      assign pwm = assigned && ch_if.pwm_on[asg - 2'h1];
      assign run = assigned && ch_if.running[asg - 2'h1];

      // Wanted gate levels after protection, before dead time
      always_comb begin
        want_h = 1'b0;
        want_l = 1'b0;
        if (!assigned) begin
          want_h = bridge_high_side_enable_i[b];
          want_l = bridge_low_side_enable_i[b] && !want_h;
        end else if (bridge_high_side_enable_i[b]) begin
          if (!run) begin
            want_l = free_wheeling_i[b];
          end else begin
            want_h = pwm;
            want_l = free_wheeling_i[b] && !pwm;
          end
        end else if (bridge_low_side_enable_i[b]) begin
          want_l = run && pwm;
          want_h = free_wheeling_i[b] && run && !pwm;
        end
        if (all_off) begin
          want_h = 1'b0;
          want_l = 1'b0;
        end
        if (high_side_overcurrent_flag_o[b] || oc_h[b]) want_h = 1'b0;
        if (low_side_overcurrent_flag_o[b] || oc_l[b])  want_l = 1'b0;
      end

      // Leg sequencer: a switch only turns on after dead time in OFF
      always_ff @(posedge core_clk_i) begin
        if (rst_all) begin
          st       <= HBPWM_ST_OFF;
          dead_cnt <= '0;
        end else begin
          unique case (st)
            HBPWM_ST_HIGH: if (!want_h) st <= HBPWM_ST_DEAD;
            HBPWM_ST_LOW:  if (!want_l) st <= HBPWM_ST_DEAD;
            HBPWM_ST_DEAD: begin
              dead_cnt <= dead_cnt + 4'h1;
              if (dead_cnt == 4'(DEAD_CYCLES - 1)) begin
                dead_cnt <= '0;
                st       <= HBPWM_ST_OFF;
              end
            end
            HBPWM_ST_OFF: begin
              if (want_h)      st <= HBPWM_ST_HIGH;
              else if (want_l) st <= HBPWM_ST_LOW;
            end
          endcase
        end
      end

      // Gates straight from flops; protection acts without waiting
      always_ff @(posedge core_clk_i) begin
        if (rst_all) begin
          high_gate_o[b] <= 1'b0;
          low_gate_o[b]  <= 1'b0;
        end else begin
          high_gate_o[b] <= (st == HBPWM_ST_HIGH) && want_h;
          low_gate_o[b]  <= (st == HBPWM_ST_LOW) && want_l;
        end
      end
    end
  endgenerate

  // ************************************************************
  // Assertions
  // ************************************************************
  no_shoot_a: assert property (@(posedge core_clk_i) disable iff (rst_all)
    (high_gate_o & low_gate_o) == '0)
    else $error("both sides of a bridge on");
  tsd_off_a: assert property (@(posedge core_clk_i) disable iff (rst_all)
    global_status_o[GS_TSD] |=> (high_gate_o | low_gate_o) == '0)
    else $error("output on during thermal shutdown");
  oc_off_a: assert property (@(posedge core_clk_i) disable iff (rst_all)
    high_side_overcurrent_flag_o[0] |=> !high_gate_o[0])
    else $error("overcurrent switch turned on");
  oc_latch_a: assert property (@(posedge core_clk_i) disable iff (rst_all)
    oc_h[0] |=> high_side_overcurrent_flag_o[0] && global_status_o[GS_LE])
    else $error("overcurrent not latched");
  fault_pin_a: assert property (@(posedge core_clk_i) disable iff (rst_all)
    global_status_o[GS_TPW] |-> !fault_indicator_n_o)
    else $error("fault pin high with flag set");
  uv_flag_a: assert property (@(posedge core_clk_i) disable iff (rst_all)
    s_uv |=> global_status_o[GS_UV] ##1 (high_gate_o | low_gate_o) == '0)
    else $error("undervoltage not handled");
  ov_flag_a: assert property (@(posedge core_clk_i) disable iff (rst_all)
    s_ov |=> global_status_o[GS_OV])
    else $error("overvoltage not latched");
  sleep_off_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !en_s2 |=> (high_gate_o | low_gate_o) == '0 && global_status_o == '0)
    else $error("sleep left outputs or flags");
  tpw_keep_a: assert property (@(posedge core_clk_i) disable iff (rst_all)
    (global_status_o[GS_TPW] && !clear_global_i[GS_TPW])
      |=> global_status_o[GS_TPW])
    else $error("prewarning lost without clear");
  pwm_cv: cover property (@(posedge core_clk_i) disable iff (rst_all)
    high_gate_o[0] ##[1:300] low_gate_o[0]);
  tsd_cv: cover property (@(posedge core_clk_i) disable iff (rst_all)
    global_status_o[GS_TSD]);
  oc_cv: cover property (@(posedge core_clk_i) disable iff (rst_all)
    low_side_overcurrent_flag_o[1]);
endmodule

// ==== hbpwm_pkg.sv ====
// Package: constants and types for the half-bridge PWM and fault block
package hbpwm_pkg;
  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int NUM_BRIDGES  = 8;
  localparam int NUM_CHANNELS = 3;
  localparam int DUTY_BITS    = 8;
  // ************************************************************
  // Clock and PWM timing
  // ************************************************************
  localparam int CLK_HZ        = 10_000_000;
  localparam int TICKS_PER_PER = 256;              // 8-bit duty steps
  localparam int RATE_80_HZ    = 80;
  localparam int RATE_100_HZ   = 100;
  localparam int RATE_200_HZ   = 200;
  localparam int RATE_2K_HZ    = 2000;
  // Prescale cycles per duty step, rounded down
  localparam int PRE_80   = CLK_HZ / (RATE_80_HZ * TICKS_PER_PER);
  localparam int PRE_100  = CLK_HZ / (RATE_100_HZ * TICKS_PER_PER);
  localparam int PRE_200  = CLK_HZ / (RATE_200_HZ * TICKS_PER_PER);
  localparam int PRE_2K   = CLK_HZ / (RATE_2K_HZ * TICKS_PER_PER);
  localparam int PRE_BITS = 16;
  // Dead time between one switch off and the other on
  localparam int DEAD_NS     = 500;
  localparam int CLK_NS      = 100;
  localparam int DEAD_CYCLES = (DEAD_NS + CLK_NS - 1) / CLK_NS;
  // ************************************************************
  // Encodings and reset values
  // ************************************************************
  localparam logic [1:0] RATE_OFF  = 2'h0;
  localparam logic [1:0] RATE_80   = 2'h1;
  localparam logic [1:0] RATE_100  = 2'h2;
  localparam logic [1:0] RATE_200  = 2'h3;
  localparam logic [1:0] ASSIGN_NONE = 2'h0;       // continuous mode
  localparam logic [7:0] DUTY_RST  = 8'h00;
  // Global status bit positions
  localparam int GS_POR_SEEN = 0;
  localparam int GS_TPW      = 1;
  localparam int GS_TSD      = 2;
  localparam int GS_OV       = 4;
  localparam int GS_UV       = 5;
  localparam int GS_LE       = 6;
  localparam logic [7:0] GS_RST = 8'h00;
  typedef enum logic [1:0] {
    HBPWM_ST_OFF  = 2'b00,
    HBPWM_ST_HIGH = 2'b01,
    HBPWM_ST_LOW  = 2'b10,
    HBPWM_ST_DEAD = 2'b11
  } hbpwm_leg_t;
endpackage

// ==== hbpwm_chan_if.sv ====
// Interface: shared PWM channel levels toward the bridge legs
`timescale 1ns/1ps
interface hbpwm_chan_if;
  logic [hbpwm_pkg::NUM_CHANNELS-1:0] pwm_on;
  logic [hbpwm_pkg::NUM_CHANNELS-1:0] running;
  modport source (output pwm_on, output running);
  modport sink   (input pwm_on, input running);
endinterface

// ==== hbpwm_channel.sv ====
// Module: one PWM channel with period-aligned settings update
`timescale 1ns/1ps
module hbpwm_channel
  import hbpwm_pkg::*;
#(
  parameter int DW = DUTY_BITS
) (
  // Clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          resetn_i,
  // Settings
  input  wire logic [DW-1:0] duty_i,
  input  wire logic [1:0]    rate_i,
  input  wire logic          fast_i,
  // Channel state
  output logic               pwm_on_o,
  output logic               running_o
);
  logic [DW-1:0]       duty_act;
  logic [1:0]          rate_act;
  logic                fast_act;
  logic [PRE_BITS-1:0] pre_cnt;
  logic [DW-1:0]       step;
  logic                tick;
  logic                period_end;

  // Prescale length for the active rate (fast bit wins)
  function automatic logic [PRE_BITS-1:0] pre_len(input logic f,
                                                  input logic [1:0] r);
    if (f) return PRE_BITS'(PRE_2K - 1);
    unique case (r)
      RATE_80:  return PRE_BITS'(PRE_80 - 1);
      RATE_100: return PRE_BITS'(PRE_100 - 1);
      RATE_200: return PRE_BITS'(PRE_200 - 1);
      default:  return PRE_BITS'(0);
    endcase
  endfunction

  assign tick       = (pre_cnt == pre_len(fast_act, rate_act));
  assign period_end = tick && (step == {DW{1'b1}});

  // ************************************************************
  // Active settings: taken at a period boundary or while stopped
  // ************************************************************
  // Stopped channel loads at once so writing a rate starts a period
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      duty_act <= DUTY_RST;
      rate_act <= RATE_OFF;
      fast_act <= 1'b0;
    end else if (!running_o || period_end) begin
      duty_act <= duty_i;
      rate_act <= rate_i;
      fast_act <= fast_i;
    end
  end

  // Prescaler and step counter
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || !running_o) begin
      pre_cnt <= '0;
      step    <= '0;
    end else if (tick) begin
      pre_cnt <= '0;
      step    <= step + 1'b1;
    end else begin
      pre_cnt <= pre_cnt + 1'b1;
    end
  end

  // Output: on while step is below duty, held off when stopped
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      pwm_on_o  <= 1'b0;
      running_o <= 1'b0;
    end else begin
      running_o <= (rate_act != RATE_OFF) || fast_act;
      pwm_on_o  <= running_o && (step < duty_act);
    end
  end

  // Assertions
  stop_off_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !running_o |=> !pwm_on_o) else $error("stopped channel drove on");
  hold_duty_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (running_o && !period_end) |=> $stable(duty_act))
    else $error("duty changed mid period");
  run_cv: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    running_o && pwm_on_o);
endmodule

// ==== hbpwm_host.sv ====
// Host model: drives bridge and channel settings toward the block
`timescale 1ns/1ps
module hbpwm_host
  import hbpwm_pkg::*;
(
  // Clock
  input  wire logic   core_clk_i,
  // Settings toward the block
  output logic [7:0]  hs_en_o,
  output logic [7:0]  ls_en_o,
  output logic [15:0] assign_o,
  output logic [7:0]  fw_o,
  output logic [23:0] duty_o,
  output logic [5:0]  rate_o,
  output logic [2:0]  fast_o
);
  // ************************************************************
  // Settings tasks, changed only at falling edges
  // ************************************************************
  task automatic zero();
    hs_en_o  = 8'h00;
    ls_en_o  = 8'h00;
    assign_o = 16'h0000;
    fw_o     = 8'h00;
    duty_o   = 24'h000000;
    rate_o   = 6'h00;
    fast_o   = 3'h0;
  endtask
  // Start-up order: stop, assign, duty, rate; enable comes last
  task automatic pwm_setup(input int b, input int c, input logic [7:0] d,
                           input logic [1:0] r, input logic f);
    @(negedge core_clk_i);
    rate_o[2*c +: 2] = RATE_OFF;
    fast_o[c] = 1'b0;
    @(negedge core_clk_i);
    assign_o[2*b +: 2] = 2'(c + 1);
    @(negedge core_clk_i);
    duty_o[8*c +: 8] = d;
    @(negedge core_clk_i);
    rate_o[2*c +: 2] = r;
    fast_o[c] = f;
  endtask
  task automatic set_en(input int b, input logic hs, input logic ls,
                        input logic fw);
    @(negedge core_clk_i);
    hs_en_o[b] = hs;
    ls_en_o[b] = ls;
    fw_o[b] = fw;
  endtask
  initial zero();
endmodule

// ==== tb.sv ====
// Testbench: gate drive, PWM and fault latching scenarios
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("mismatch %s exp %h got %h", nm, exp, got); \
    end \
  end
module tb;
  import hbpwm_pkg::*;
  localparam int PER = PRE_2K * TICKS_PER_PER;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic enable_i = 1'b1;
  logic [7:0] hs_oc = 8'h00, ls_oc = 8'h00, hs_ol = 8'h00, ls_ol = 8'h00;
  logic [3:0] gcond = 4'h0;
  logic [7:0] c_hs_oc = 8'h00, c_ls_oc = 8'h00, c_hs_ol = 8'h00;
  logic [7:0] c_ls_ol = 8'h00, c_glob = 8'h00;
  logic [7:0] hs_en, ls_en, fw, hg, lg, hoc, loc, hol, lol, gs;
  logic [15:0] asg;
  logic [23:0] duty;
  logic [5:0] rate;
  logic [2:0] fast;
  logic fault_n;
  int fails = 0;
  int n_checks = 0;
  // ************************************************************
  // Clock, host model and block
  // ************************************************************
  initial forever #50 core_clk_i = ~core_clk_i;
  hbpwm_host host_u (.core_clk_i(core_clk_i), .hs_en_o(hs_en),
    .ls_en_o(ls_en), .assign_o(asg), .fw_o(fw), .duty_o(duty),
    .rate_o(rate), .fast_o(fast));
  hbpwm_top dut_u (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .enable_i(enable_i), .bridge_high_side_enable_i(hs_en),
    .bridge_low_side_enable_i(ls_en),
    .bridge_channel_assign_control_i(asg), .free_wheeling_i(fw),
    .duty_cycle_control_i(duty), .channel_rate_field_i(rate),
    .channel_fast_rate_bit_i(fast), .hs_overcurrent_i(hs_oc),
    .ls_overcurrent_i(ls_oc), .hs_open_load_i(hs_ol),
    .ls_open_load_i(ls_ol), .temp_warn_i(gcond[0]),
    .temp_shutdown_i(gcond[1]), .supply_under_i(gcond[2]),
    .supply_over_i(gcond[3]), .clear_hs_oc_i(c_hs_oc),
    .clear_ls_oc_i(c_ls_oc), .clear_hs_ol_i(c_hs_ol),
    .clear_ls_ol_i(c_ls_ol), .clear_global_i(c_glob),
    .high_gate_o(hg), .low_gate_o(lg),
    .high_side_overcurrent_flag_o(hoc), .low_side_overcurrent_flag_o(loc),
    .high_side_open_load_flag_o(hol), .low_side_open_load_flag_o(lol),
    .global_status_o(gs), .fault_indicator_n_o(fault_n));
  // Both sides of one bridge must never conduct together
  always @(negedge core_clk_i)
    if (resetn_i) `CHK("overlap", 8'h00, hg & lg)
  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic do_reset();
    host_u.zero();
    resetn_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge core_clk_i); // Sleep synchroniser settles
  endtask
  task automatic wait_gate(input int b, input logic hs, input logic v,
                           input int lim);
    for (int i = 0; i <= lim; i++) begin
      if ((hs ? hg[b] : lg[b]) === v) return;
      @(negedge core_clk_i);
    end
    fails++;
    $display("mismatch gate_wait exp %h got timeout", v);
    finish_test();
  endtask
  // Length of the current high pulse, bounded so a stuck gate ends
  task automatic high_len(input int b, input int lim, output int n);
    n = 0;
    while (hg[b] === 1'b1 && n < lim) begin
      n++;
      @(negedge core_clk_i);
    end
  endtask
  task automatic count_high(input int b, output int n);
    n = 0;
    repeat (PER) begin
      @(negedge core_clk_i);
      if (hg[b] === 1'b1) n++;
    end
  endtask
  // Pulse length may shift by up to two cycles of gate latency
  function automatic logic near(int a, int b);
    return (a - b <= 2) && (b - a <= 2);
  endfunction
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_cont();
    host_u.set_en(0, 1'b1, 1'b0, 1'b0);
    wait_gate(0, 1'b1, 1'b1, 10);
    `CHK("cont_low", 1'b0, lg[0])
    host_u.set_en(0, 1'b0, 1'b1, 1'b0);
    wait_gate(0, 1'b0, 1'b1, 20);
    `CHK("cont_high", 1'b0, hg[0])
    host_u.set_en(0, 1'b1, 1'b0, 1'b0);
    wait_gate(0, 1'b1, 1'b1, 20);
  endtask
  task automatic t_oc();
    hs_oc[0] = 1'b1;
    repeat (4) @(negedge core_clk_i);
    `CHK("oc_flag", 1'b1, hoc[0])
    `CHK("oc_le", 1'b1, gs[GS_LE])
    `CHK("oc_fault", 1'b0, fault_n)
    `CHK("oc_gate", 1'b0, hg[0])
    c_hs_oc[0] = 1'b1;
    @(negedge core_clk_i);
    c_hs_oc[0] = 1'b0;
    hs_oc[0] = 1'b0;
    repeat (6) @(negedge core_clk_i);
    `CHK("oc_kept", 1'b1, hoc[0])
    `CHK("oc_still_off", 1'b0, hg[0])
    c_hs_oc[0] = 1'b1;
    c_glob = 8'h40;
    @(negedge core_clk_i);
    c_hs_oc[0] = 1'b0;
    c_glob = 8'h00;
    wait_gate(0, 1'b1, 1'b1, 20);
    `CHK("oc_clear", 1'b0, hoc[0])
  endtask
  task automatic t_ol();
    ls_ol[0] = 1'b1;
    hs_ol[1] = 1'b1;
    ls_oc[1] = 1'b1;
    repeat (4) @(negedge core_clk_i);
    ls_ol[0] = 1'b0;
    hs_ol[1] = 1'b0;
    ls_oc[1] = 1'b0;
    repeat (4) @(negedge core_clk_i);
    `CHK("ol_flag", 1'b1, lol[0])
    `CHK("ol_hflag", 1'b1, hol[1])
    `CHK("oc_lflag", 1'b1, loc[1])
    `CHK("ol_le", 1'b1, gs[GS_LE])
    `CHK("ol_gate", 1'b1, hg[0])
    c_ls_ol[0] = 1'b1;
    c_hs_ol[1] = 1'b1;
    c_ls_oc[1] = 1'b1;
    c_glob = 8'h40;
    @(negedge core_clk_i);
    c_ls_ol[0] = 1'b0;
    c_hs_ol[1] = 1'b0;
    c_ls_oc[1] = 1'b0;
    c_glob = 8'h00;
    `CHK("ol_clear", 1'b0, lol[0])
    `CHK("ol_hclear", 1'b0, hol[1])
    `CHK("oc_lclear", 1'b0, loc[1])
  endtask
  task automatic t_glob();
    int gb [4] = '{GS_TPW, GS_TSD, GS_UV, GS_OV};
    for (int k = 0; k < 4; k++) begin
      gcond[k] = 1'b1;
      repeat (4) @(negedge core_clk_i);
      `CHK("gs_set", 1'b1, gs[gb[k]])
      `CHK("gs_fault", 1'b0, fault_n)
      `CHK("gs_gate", k == 0, hg[0])
      gcond[k] = 1'b0;
      repeat (8) @(negedge core_clk_i);
      `CHK("gs_after", k != 1, hg[0])
      `CHK("gs_kept", 1'b1, gs[gb[k]])
      c_glob = 8'h01 << gb[k];
      @(negedge core_clk_i);
      c_glob = 8'h00;
      wait_gate(0, 1'b1, 1'b1, 20);
      `CHK("gs_clear", 1'b0, gs[gb[k]])
      `CHK("gs_idle", 1'b1, fault_n)
    end
  endtask
  task automatic t_sleep();
    // Acknowledge bit and a warning set, so sleep has state to wipe
    c_glob = 8'h01;
    gcond[0] = 1'b1;
    @(negedge core_clk_i);
    c_glob = 8'h00;
    repeat (3) @(negedge core_clk_i);
    `CHK("sl_pre", 8'h03, gs)
    gcond[0] = 1'b0;
    enable_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    `CHK("sl_gates", 16'h0000, {hg, lg})
    `CHK("sl_status", 8'h00, gs)
    `CHK("sl_fault", 1'b1, fault_n)
    enable_i = 1'b1;
  endtask
  task automatic t_pwm();
    int n;
    do_reset();
    host_u.pwm_setup(2, 0, 8'h80, RATE_OFF, 1'b1);
    host_u.set_en(2, 1'b1, 1'b0, 1'b0);
    wait_gate(2, 1'b1, 1'b1, PER + 50);
    wait_gate(2, 1'b1, 1'b0, PER);
    wait_gate(2, 1'b1, 1'b1, PER);
    host_u.duty_o[7:0] = 8'h40; // Changed just after a period start
    count_high(2, n);
    `CHK("duty_old", 1'b1, near(n, 128 * PRE_2K))
    count_high(2, n);
    `CHK("duty_new", 1'b1, near(n, 64 * PRE_2K))
  endtask
  task automatic t_rates();
    int n;
    int pre [3] = '{PRE_80, PRE_100, PRE_200};
    // One duty step: the high pulse lasts one prescale of the rate
    for (int r = 1; r < 4; r++) begin
      do_reset();
      host_u.pwm_setup(3, 1, 8'h01, 2'(r), 1'b0);
      host_u.set_en(3, 1'b1, 1'b0, 1'b0);
      wait_gate(3, 1'b1, 1'b1, 40);
      `CHK("rate_on", 1'b1, hg[3])
      high_len(3, 600, n);
      `CHK("rate_len", 1'b1, near(n, pre[r-1]))
    end
    do_reset();
    host_u.pwm_setup(4, 2, 8'h80, RATE_OFF, 1'b0);
    host_u.set_en(4, 1'b1, 1'b0, 1'b1);
    wait_gate(4, 1'b0, 1'b1, 30);
    `CHK("fw_stop_hs", 1'b0, hg[4])
    // Running channel: low side must take over in the off phase
    host_u.fast_o[2] = 1'b1;
    wait_gate(4, 1'b1, 1'b1, PER + 50);
    wait_gate(4, 1'b0, 1'b1, PER);
    `CHK("fw_run_hs", 1'b0, hg[4])
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    do_reset();
    `CHK("rst_fault", 1'b1, fault_n)
    t_cont();
    t_oc();
    t_ol();
    t_glob();
    t_sleep();
    t_pwm();
    t_rates();
    finish_test();
  end
endmodule
